// ==== core/tmc_consts.svh ====
// Behaviour
// - upconverter unlock or module absence mutes operate
// - operate on remote low, panel, serial
// - refuse operate while heatsink over temperature
// - refuse operate while mute faults present
// - refuse operate while amplifier absent interlock high
// - standby keeps amplifier enable low
// - standby on remote low, panel, serial
// - auto standby after ten seconds modulation loss
// - auto standby returns when modulation returns
// - operate entry permitted only with RF loop closed; return from auto standby skips the loop check
// - open RF loop forces mute
// - mute keeps supply on, IF processor muted
// - standby disables IF, supply, operate lamp
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH
`define TMC_CLK_HZ 100000000
`define TMC_LOSS_SEC 10
`define TMC_DEB_CYCLES 16'h0400
`define TMC_BUS_ADDR_CTRL 4'h0
`define TMC_BUS_ADDR_STAT 4'h4
`define TMC_CTRL_AUTO_BIT 0
`define TMC_CTRL_RESET 32'h00000000
`endif

// ==== core/tmc_pkg.sv ====
package tmc_pkg;
  // top-level mode of the controller
  typedef enum logic [1:0] {
    TMC_STANDBY,
    TMC_OPERATE,
    TMC_AUTO_STBY
  } tmc_mode_e;
endpackage

// ==== core/tmc_debounce.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.svh"
// two-flop synchroniser then a stability counter; output moves only
// after the input held steady for DEB cycles
module tmc_debounce #(
  parameter logic [15:0] DEB = `TMC_DEB_CYCLES,
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_q, s1_d; // first stage, read only by s2
  logic s2_q, s2_d;
  logic [15:0] cnt_q, cnt_d;
  logic lvl_q, lvl_d;

  // next-state: count while synced level differs from output
  always_comb begin
    s1_d = pin_i;
    s2_d = s1_q;
    lvl_d = lvl_q;
    cnt_d = 16'h0000;
    if (s2_q != lvl_q) begin
      if (cnt_q >= DEB - 16'h0001) begin
        lvl_d = s2_q; // stable long enough
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  // register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      cnt_q <= 16'h0000;
      lvl_q <= RST_VAL;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
    end
  end

  assign level_o = lvl_q;
endmodule
`default_nettype wire

// ==== core/tmc_mode_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.svh"
// operate/standby controller with mute sub-state and auto standby
module tmc_mode_ctrl
  import tmc_pkg::*;
#(
  parameter int unsigned CLK_HZ = `TMC_CLK_HZ,
  parameter int unsigned LOSS_CYCLES = `TMC_LOSS_SEC * CLK_HZ,
  parameter logic [15:0] DEB_CYCLES = `TMC_DEB_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // remote discrete pins, active low, asynchronous
  input wire logic rmt_operate_n_i,
  input wire logic rmt_standby_n_i,
  input wire logic rf_loop_open_i, // high when loop not grounded
  // same-clock requests and status, one-cycle pulses or levels
  input wire logic panel_operate_select_i,
  input wire logic panel_standby_key_i,
  input wire logic serial_operate_cmd_i,
  input wire logic serial_standby_cmd_i,
  input wire logic upc_unlocked_i,
  input wire logic upc_absent_i,
  input wire logic ifp_absent_i,
  input wire logic pa_over_temp_i,
  input wire logic pa_absent_i,
  input wire logic mod_present_i,
  // outputs, all registered
  output logic amp_enable_o,
  output logic ifp_enable_o,
  output logic ifp_mute_o,
  output logic supply32_enable_o,
  output logic operate_led_o,
  output logic mute_led_o
);
  tmc_mode_e mode_q, mode_d;
  logic rop_lvl, rst_lvl, loop_lvl; // debounced pin levels
  logic rop_prev_q, rop_prev_d; // edge detect on debounced levels
  logic rsb_prev_q, rsb_prev_d;
  logic auto_en_q, auto_en_d; // software auto-standby enable
  logic [31:0] loss_q, loss_d; // modulation-loss counter
  logic loss_done;
  logic mute_c; // any mute cause present, loop included
  logic block_op; // operate entry refused this cycle
  logic op_req; // operate asked by any source
  logic sb_req; // standby asked by any source
  logic ack_q, ack_d; // bus acknowledge
  logic [31:0] rdat_q, rdat_d; // read data, zero outside ack
  logic amp_q, amp_d; // power amplifier enable
  logic ifen_q, ifen_d; // IF processor enable
  logic ifmu_q, ifmu_d; // IF processor mute
  logic sup_q, sup_d; // +32 V supply stage enable
  logic opl_q, opl_d; // operate lamp
  logic mul_q, mul_d; // mute lamp

  // RF loop and remote pins pass synchroniser and debouncer
  tmc_debounce #(.DEB(DEB_CYCLES), .RST_VAL(1'b1)) u_deb_op (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(rmt_operate_n_i),
    .level_o(rop_lvl)
  );
  tmc_debounce #(.DEB(DEB_CYCLES), .RST_VAL(1'b1)) u_deb_sb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(rmt_standby_n_i),
    .level_o(rst_lvl)
  );
  // loop resets as open so nothing runs before the pin is seen
  tmc_debounce #(.DEB(DEB_CYCLES), .RST_VAL(1'b1)) u_deb_lp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(rf_loop_open_i),
    .level_o(loop_lvl)
  );

  // fault and request decoding
  always_comb begin
    // open loop joins the mute faults
    mute_c = upc_unlocked_i | upc_absent_i | ifp_absent_i
           | loop_lvl;
    block_op = pa_over_temp_i
             | mute_c
             | pa_absent_i
             | loop_lvl;
    // remote lines act on falling debounced edge, so a held low
    // does not fight a later command from another source
    op_req = (~rop_lvl & rop_prev_q) | panel_operate_select_i
           | serial_operate_cmd_i;
    sb_req = (~rst_lvl & rsb_prev_q) | panel_standby_key_i
           | serial_standby_cmd_i;
    rop_prev_d = rop_lvl;
    rsb_prev_d = rst_lvl;
  end

  // modulation-loss timer
  always_comb begin
    loss_done = (loss_q >= LOSS_CYCLES - 1);
    loss_d = 32'h00000000;
    if (auto_en_q && mode_q == TMC_OPERATE && !mod_present_i) begin
      loss_d = loss_done ? loss_q : loss_q + 32'h00000001;
    end
  end

  // mode state machine, standby takes priority over operate
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      TMC_STANDBY: begin
        if (!sb_req && op_req && !block_op) begin
          mode_d = TMC_OPERATE;
        end
      end
      TMC_OPERATE: begin
        if (sb_req) begin
          mode_d = TMC_STANDBY;
        end else if (auto_en_q && loss_done && !mod_present_i) begin
          mode_d = TMC_AUTO_STBY;
        end
      end
      TMC_AUTO_STBY: begin
        if (sb_req || !auto_en_q) begin
          mode_d = TMC_STANDBY;
        end else if (mod_present_i) begin
          mode_d = TMC_OPERATE;
        end
      end
      default: mode_d = TMC_STANDBY;
    endcase
  end

  // outputs follow the next mode so they settle with it
  always_comb begin
    amp_d = 1'b0;
    ifen_d = 1'b0;
    ifmu_d = 1'b1;
    sup_d = 1'b0;
    opl_d = 1'b0;
    mul_d = 1'b1;
    if (mode_d == TMC_OPERATE) begin
      amp_d = 1'b1;
      sup_d = 1'b1;
      opl_d = 1'b1;
      ifen_d = 1'b1;
      ifmu_d = mute_c;
      mul_d = mute_c;
    end
    // standby and auto standby: enables and operate lamp off, IF mute and mute lamp on
  end

  // wishbone: one-cycle ack, ack dropped the cycle after
  always_comb begin
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    auto_en_d = auto_en_q;
    rdat_d = 32'h00000000;
    // the write lands at the edge where the master sees ack high, so
    // a request is only acted on once it has been answered
    if (wb_cyc_i && wb_stb_i && ack_q && wb_we_i
        && wb_adr_i == `TMC_BUS_ADDR_CTRL && wb_sel_i[0]) begin
      auto_en_d = wb_dat_i[`TMC_CTRL_AUTO_BIT];
    end
    if (ack_d && !wb_we_i) begin
      case (wb_adr_i)
        `TMC_BUS_ADDR_CTRL: rdat_d = {31'h00000000, auto_en_q};
        `TMC_BUS_ADDR_STAT: rdat_d = {24'h000000, loop_lvl, pa_absent_i,
                                      pa_over_temp_i, mute_c, ifmu_q,
                                      amp_q, mode_q};
        default: rdat_d = 32'h00000000; // unmapped reads zero
      endcase
    end
  end

  // register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= TMC_STANDBY;
      rop_prev_q <= 1'b1;
      rsb_prev_q <= 1'b1;
      auto_en_q <= 1'(`TMC_CTRL_RESET);
      loss_q <= 32'h00000000;
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
      amp_q <= 1'b0;
      ifen_q <= 1'b0;
      ifmu_q <= 1'b1;
      sup_q <= 1'b0;
      opl_q <= 1'b0;
      mul_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      rop_prev_q <= rop_prev_d;
      rsb_prev_q <= rsb_prev_d;
      auto_en_q <= auto_en_d;
      loss_q <= loss_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      amp_q <= amp_d;
      ifen_q <= ifen_d;
      ifmu_q <= ifmu_d;
      sup_q <= sup_d;
      opl_q <= opl_d;
      mul_q <= mul_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign amp_enable_o = amp_q;
  assign ifp_enable_o = ifen_q;
  assign ifp_mute_o = ifmu_q;
  assign supply32_enable_o = sup_q;
  assign operate_led_o = opl_q;
  assign mute_led_o = mul_q;

  // checks: each watches registered outputs or the next-state logic
  a_standby_amp_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_q != TMC_OPERATE |-> !amp_q)
    else $error("amplifier enabled outside operate");
  a_standby_outputs: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_q == TMC_STANDBY |-> !sup_q && !ifen_q && mul_q && !opl_q)
    else $error("standby outputs wrong");
  a_auto_outputs: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_q == TMC_AUTO_STBY |-> !amp_q && !sup_q && !ifen_q && ifmu_q)
    else $error("auto standby left outputs on");
  a_mute_supply_on: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode_q == TMC_OPERATE && $past(mute_c) && $past(mode_d) == TMC_OPERATE)
    |-> sup_q && ifmu_q)
    else $error("mute lost supply or IF mute");
  a_no_entry_hot: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_q == TMC_STANDBY && pa_over_temp_i |=> mode_q != TMC_OPERATE)
    else $error("entered operate while hot");
  a_no_entry_absent: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_q == TMC_STANDBY && pa_absent_i |=> mode_q != TMC_OPERATE)
    else $error("entered operate without amplifier");
  a_no_entry_mute: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_q == TMC_STANDBY && mute_c |=> mode_q != TMC_OPERATE)
    else $error("entered operate while muted");
  a_no_entry_loop: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_q == TMC_STANDBY && loop_lvl |=> mode_q != TMC_OPERATE)
    else $error("entered operate with loop open");
  a_op_entry: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_q == TMC_STANDBY && op_req && !sb_req && !block_op
    |=> mode_q == TMC_OPERATE)
    else $error("operate request not taken");
  a_sb_entry: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_q != TMC_STANDBY && sb_req |=> mode_q == TMC_STANDBY)
    else $error("standby request not taken");
  a_loop_mutes: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_q == TMC_OPERATE && loop_lvl && mode_d == TMC_OPERATE
    |=> ifmu_q && mul_q)
    else $error("open loop did not mute");
  a_fault_mutes: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_d == TMC_OPERATE && upc_unlocked_i |=> ifmu_q && amp_q)
    else $error("unlock did not mute in operate");
  a_fault_clears: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_d == TMC_OPERATE && !mute_c |=> !ifmu_q && !mul_q && amp_q)
    else $error("mute held without a fault");
  a_standby_wins: assert property (
    @(posedge clk_i) disable iff (rst_i)
    sb_req && op_req |=> mode_q != TMC_OPERATE)
    else $error("operate won over standby");
  a_loss_timeout: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_q == TMC_OPERATE && loss_done && auto_en_q && !mod_present_i
    && !sb_req |=> mode_q == TMC_AUTO_STBY)
    else $error("no auto standby after loss");
  a_auto_return: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mode_q == TMC_AUTO_STBY && auto_en_q && mod_present_i && !sb_req
    |=> mode_q == TMC_OPERATE)
    else $error("no return after modulation");
  a_timer_idle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !auto_en_q || mod_present_i |=> loss_q == 32'h00000000)
    else $error("loss timer held state");
  a_wb_ack_pulse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_wb_ack_cause: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without a request");
endmodule
`default_nettype wire

// ==== verification/tmc_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
// remote lines, front panel and serial host on the far side
module tmc_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [1:0] op_src_i, // 1 serial, 2 panel, 3 remote
  input wire logic [1:0] sb_src_i,
  output logic s_op_o,
  output logic s_sb_o,
  output logic p_op_o,
  output logic p_sb_o,
  output var logic r_op_n_o,
  output var logic r_sb_n_o
);
  logic [3:0] op_q; // remote low time left
  logic [3:0] sb_q;
  // panel and serial requests are single-cycle pulses
  always_ff @(posedge clk_i) begin
    s_op_o <= go_i && op_src_i == 2'h1;
    p_op_o <= go_i && op_src_i == 2'h2;
    s_sb_o <= go_i && sb_src_i == 2'h1;
    p_sb_o <= go_i && sb_src_i == 2'h2;
    if (rst_i) begin
      op_q <= 4'h0;
      sb_q <= 4'h0;
    end else if (go_i) begin
      // hold long enough to outlast sync plus debounce
      op_q <= (op_src_i == 2'h3) ? 4'hC : 4'h0;
      sb_q <= (sb_src_i == 2'h3) ? 4'hC : 4'h0;
    end else begin
      op_q <= (op_q != 4'h0) ? op_q - 4'h1 : op_q;
      sb_q <= (sb_q != 4'h0) ? sb_q - 4'h1 : sb_q;
    end
  end
  // open collector: released line floats to the pull-up level
  assign r_op_n_o = (op_q == 4'h0);
  assign r_sb_n_o = (sb_q == 4'h0);
endmodule
`default_nettype wire

// ==== verification/tb_translator_mode_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_translator_mode_controller;
  import tmc_pkg::*;
  typedef struct packed {
    logic [5:0] blk; // loop,unl,upc,ifp,temp,pa
    logic [1:0] op;
    logic [1:0] sb;
    logic ex;
  } tmc_row_s;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, go;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic rmt_operate_n_i, rmt_standby_n_i, rf_loop_open_i;
  logic panel_operate_select_i, panel_standby_key_i;
  logic serial_operate_cmd_i, serial_standby_cmd_i;
  logic upc_unlocked_i, upc_absent_i, ifp_absent_i, pa_over_temp_i;
  logic pa_absent_i, mod_present_i, amp_enable_o, ifp_enable_o;
  logic ifp_mute_o, supply32_enable_o, operate_led_o, mute_led_o;
  logic [1:0] op, sb;
  int err_count, n_checks;
  tmc_row_s rows [9] = '{
    '{6'h00, 2'h1, 2'h1, 1'b1}, '{6'h00, 2'h2, 2'h2, 1'b1},
    '{6'h00, 2'h3, 2'h3, 1'b1}, '{6'h02, 2'h1, 2'h1, 1'b0},
    '{6'h01, 2'h2, 2'h2, 1'b0}, '{6'h10, 2'h1, 2'h1, 1'b0},
    '{6'h08, 2'h1, 2'h1, 1'b0}, '{6'h04, 2'h1, 2'h1, 1'b0},
    '{6'h20, 2'h1, 2'h1, 1'b0}};
  // short counts keep the run brief
  tmc_mode_ctrl #(.LOSS_CYCLES(50), .DEB_CYCLES(16'h0004)) dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .rmt_operate_n_i, .rmt_standby_n_i,
    .rf_loop_open_i, .panel_operate_select_i, .panel_standby_key_i,
    .serial_operate_cmd_i, .serial_standby_cmd_i, .upc_unlocked_i,
    .upc_absent_i, .ifp_absent_i, .pa_over_temp_i, .pa_absent_i,
    .mod_present_i, .amp_enable_o, .ifp_enable_o, .ifp_mute_o,
    .supply32_enable_o, .operate_led_o, .mute_led_o);
  tmc_partner far (.clk_i, .rst_i, .go_i(go), .op_src_i(op), .sb_src_i(sb),
    .s_op_o(serial_operate_cmd_i), .s_sb_o(serial_standby_cmd_i),
    .p_op_o(panel_operate_select_i), .p_sb_o(panel_standby_key_i),
    .r_op_n_o(rmt_operate_n_i), .r_sb_n_o(rmt_standby_n_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic final_report();
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s exp=%h got=%h", nm, exp, got);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] a,
                    input logic [31:0] d);
    int i;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (i >= 20) begin
      err_count++;
      final_report();
    end
  endtask
  task automatic req(input logic [1:0] o, s, input int w);
    @(posedge clk_i);
    {go, op, sb} <= {1'b1, o, s};
    @(posedge clk_i);
    go <= 1'b0;
    repeat (w) @(posedge clk_i);
  endtask
  task automatic mods(input logic m, input int w);
    mod_present_i <= m;
    repeat (w) @(posedge clk_i);
  endtask
  task automatic outs(input logic [5:0] e, input string nm);
    chk(nm, {amp_enable_o, ifp_enable_o, supply32_enable_o, operate_led_o,
             ifp_mute_o, mute_led_o}, e);
  endtask
  initial begin
    {go, op, sb, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
    {wb_adr_i, wb_dat_i, rf_loop_open_i, pa_over_temp_i, pa_absent_i} = '0;
    {upc_unlocked_i, upc_absent_i, ifp_absent_i, mod_present_i} = 4'h1;
    wb_sel_i = 4'hF;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    outs(6'h03, "reset");
    rst_i <= 1'b0;
    for (int r = 0; r < 9; r++) begin
      {rf_loop_open_i, upc_unlocked_i, upc_absent_i, ifp_absent_i,
       pa_over_temp_i, pa_absent_i} <= rows[r].blk;
      repeat (12) @(posedge clk_i);
      req(rows[r].op, 2'h0, 20);
      chk("enter", amp_enable_o, rows[r].ex);
      chk("lamp", operate_led_o, rows[r].ex);
      req(2'h0, rows[r].sb, 20);
      outs(6'h03, "standby");
    end
    {rf_loop_open_i, upc_unlocked_i, upc_absent_i, ifp_absent_i,
     pa_over_temp_i, pa_absent_i} <= 6'h00;
    repeat (12) @(posedge clk_i);
    req(2'h1, 2'h0, 2);
    outs(6'h3C, "operate");
    upc_unlocked_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    outs(6'h3F, "mute");
    upc_unlocked_i <= 1'b0;
    rf_loop_open_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    outs(6'h3F, "loop");
    rf_loop_open_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    outs(6'h3C, "unmute");
    req(2'h1, 2'h1, 2);
    outs(6'h03, "tie");
    wb(1'b1, 4'h0, 32'h00000001);
    wb(1'b1, 4'h8, 32'h00000000);
    wb(1'b0, 4'h0, 32'h0);
    chk("ctrl", rd, 32'h00000001);
    wb(1'b0, 4'h8, 32'h0);
    chk("unmapped", rd, 32'h00000000);
    req(2'h1, 2'h0, 2);
    mods(1'b0, 40);
    chk("loss 40", amp_enable_o, 1'b1);
    mods(1'b0, 15);
    outs(6'h03, "auto");
    wb(1'b0, 4'h4, 32'h0);
    chk("stat", rd[1:0], 2'h2);
    mods(1'b1, 3);
    chk("return", amp_enable_o, 1'b1);
    mods(1'b0, 30);
    mods(1'b1, 2);
    mods(1'b0, 30);
    chk("restart", amp_enable_o, 1'b1);
    mods(1'b1, 2);
    wb(1'b1, 4'h0, 32'h00000000);
    mods(1'b0, 80);
    chk("off", amp_enable_o, 1'b1);
    // second reset in mid-run: loop reads open until debounced again
    wb(1'b1, 4'h0, 32'h00000001);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    outs(6'h03, "rerun reset");
    req(2'h1, 2'h0, 2);
    chk("loop after reset", amp_enable_o, 1'b0);
    wb(1'b0, 4'h0, 32'h0);
    chk("ctrl reset", rd, 32'h00000000);
    final_report();
  end
endmodule
`default_nettype wire
